//--- logic/its_target.sv
// two-wire bus target with register file, thermal flags and supply lockout
`timescale 1ns/100ps
`default_nettype none
module its_target
  import its_pkg::*;
#(
  parameter logic [39:0] CFG_DEFAULT = ITS_CFG_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic analog_undervoltage_lockout,
  input wire logic vdd_undervoltage_lockout,
  input wire logic temp_above_warn,
  input wire logic temp_above_shutdown,
  input wire logic temp_cooled,
  output logic power_stage_en,
  output logic thermal_early_warning_flag,
  output logic thermal_shutdown_latched_flag,
  output logic hs_mode,
  output logic [39:0] cfg_out
);

  typedef struct packed {
    its_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic phase;
    logic [2:0] ptr;
    logic hs;
    logic nack;
    logic scl_q;
    logic sda_q;
    logic [4:0][7:0] cfg;
    logic warn;
    logic tsd_lat;
    logic tsd_act;
    logic pwr;
    logic oe_n;
    logic drv;
  } its_core_t;

  localparam its_core_t CORE_INIT = '{
    st: ST_IDLE, cnt: 4'h0, sh: 8'h00, tx: 8'h00, phase: 1'h0, ptr: 3'h0,
    hs: 1'h0, nack: 1'h0, scl_q: 1'h1, sda_q: 1'h1, cfg: CFG_DEFAULT,
    warn: 1'h0, tsd_lat: 1'h0, tsd_act: 1'h0, pwr: 1'h0, oe_n: 1'h1, drv: 1'h0
  };

  its_core_t core_reg;
  its_core_t core_next;

  logic [ITS_IN_NUM-1:0] raw;
  logic [ITS_IN_NUM-1:0] flt;
  logic scl_s;
  logic sda_s;
  logic uv_any;
  logic rise;
  logic fall;
  logic start_evt;
  logic stop_evt;
  logic addr_done;
  logic addr_hit;
  logic hs_hit;
  logic commit;
  logic load;
  logic [7:0] rd_byte;
  logic [7:0] status;

  // every outside level is synchronised and deglitched alike
  assign raw = {temp_cooled, temp_above_shutdown, temp_above_warn,
    vdd_undervoltage_lockout, analog_undervoltage_lockout, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < ITS_IN_NUM; gi++) begin : g_in
      its_pin_filter #(
        .LEN(ITS_FILTER_CYC),
        .INIT(ITS_IN_INIT[gi])
      ) u_filt (
        .ref_clk(ref_clk),
        .reset(reset),
        .raw_in(raw[gi]),
        .clean_out(flt[gi])
      );
    end
  endgenerate

  assign scl_s = flt[ITS_IN_SCL];
  assign sda_s = flt[ITS_IN_SDA];
  assign uv_any = flt[ITS_IN_ANALOG_UV] | flt[ITS_IN_VDD_UV];

  // bus events from the filtered lines
  always_comb begin
    rise = scl_s & ~core_reg.scl_q;
    fall = ~scl_s & core_reg.scl_q;
    start_evt = scl_s & core_reg.scl_q & core_reg.sda_q & ~sda_s;
    stop_evt = scl_s & core_reg.scl_q & ~core_reg.sda_q & sda_s;
    addr_done = (core_reg.st == ST_ADDR) & fall & (core_reg.cnt == ITS_BITS_PER_BYTE);
    // general call and ten-bit headers never equal our address
    addr_hit = addr_done & ~uv_any & (core_reg.sh[7:1] == ITS_DEV_ADDR);
    hs_hit = addr_done & ~uv_any & (core_reg.sh[7:3] == ITS_HS_CODE);
    commit = (core_reg.st == ST_RACK) & fall & core_reg.phase & ~uv_any;
    load = fall & ~uv_any & (((core_reg.st == ST_AACK) & (core_reg.sh[0] != ITS_WRITE_DIR))
      | ((core_reg.st == ST_TACK) & ~core_reg.nack));
  end

  // read mux: status byte, plain registers, zero for holes
  always_comb begin
    status = 8'h00;
    status[ITS_WARN_BIT] = core_reg.warn;
    status[ITS_TSD_BIT] = core_reg.tsd_lat;
    if (core_reg.ptr < 3'(ITS_CFG_NUM)) begin
      rd_byte = core_reg.cfg[core_reg.ptr];
    end else if (core_reg.ptr == ITS_STATUS_IDX) begin
      rd_byte = status;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // protocol engine, thermal state and supply lockout
  always_comb begin
    core_next = core_reg;
    core_next.scl_q = scl_s;
    core_next.sda_q = sda_s;

    // sample on rising SCL, change our drive only after falling SCL
    case (core_reg.st)
      ST_IDLE: begin
        core_next.oe_n = 1'h1;
      end
      ST_ADDR, ST_RX: begin
        if (rise && core_reg.cnt < ITS_BITS_PER_BYTE) begin
          core_next.sh = {core_reg.sh[6:0], sda_s};
          core_next.cnt = core_reg.cnt + 4'h1;
        end else if (fall && core_reg.cnt == ITS_BITS_PER_BYTE) begin
          core_next.cnt = 4'h0;
          if (core_reg.st == ST_RX) begin
            core_next.oe_n = 1'h0;
            core_next.st = ST_RACK;
          end else if (addr_hit) begin
            core_next.oe_n = 1'h0;
            core_next.st = ST_AACK;
          end else begin
            if (hs_hit) begin
              core_next.hs = 1'h1;
            end
            core_next.st = ST_WAIT;
          end
        end
      end
      ST_AACK: begin
        if (fall) begin
          core_next.oe_n = 1'h1;
          if (core_reg.sh[0] == ITS_WRITE_DIR) begin
            core_next.phase = 1'h0;
            core_next.st = ST_RX;
          end else begin
            core_next.tx = rd_byte;
            core_next.oe_n = rd_byte[7];
            core_next.st = ST_TX;
          end
        end
      end
      ST_RACK: begin
        if (fall) begin
          core_next.oe_n = 1'h1;
          core_next.st = ST_RX;
          if (!core_reg.phase) begin
            core_next.ptr = core_reg.sh[2:0];
            core_next.phase = 1'h1;
          end else if (core_reg.ptr < 3'(ITS_CFG_NUM)) begin
            core_next.cfg[core_reg.ptr] = core_reg.sh;
          end else if (core_reg.ptr == ITS_STATUS_IDX && core_reg.sh[ITS_TSD_BIT]) begin
            core_next.tsd_lat = 1'h0;
          end
        end
      end
      ST_TX: begin
        if (fall) begin
          if (core_reg.cnt + 4'h1 == ITS_BITS_PER_BYTE) begin
            core_next.cnt = 4'h0;
            core_next.oe_n = 1'h1; // controller acknowledges
            core_next.st = ST_TACK;
          end else begin
            core_next.cnt = core_reg.cnt + 4'h1;
            core_next.tx = {core_reg.tx[6:0], 1'h0};
            core_next.oe_n = core_reg.tx[6];
          end
        end
      end
      ST_TACK: begin
        if (rise) begin
          core_next.nack = sda_s;
        end else if (fall) begin
          if (core_reg.nack) begin
            core_next.st = ST_WAIT;
          end else begin
            core_next.tx = rd_byte;
            core_next.oe_n = rd_byte[7];
            core_next.st = ST_TX;
          end
        end
      end
      ST_WAIT: begin
        core_next.oe_n = 1'h1;
      end
      default: begin
        core_next.st = ST_IDLE;
        core_next.oe_n = 1'h1;
      end
    endcase

    // a repeated start keeps the register index for the read that follows
    if (start_evt) begin
      core_next.st = ST_ADDR;
      core_next.cnt = 4'h0;
      core_next.oe_n = 1'h1;
    end
    if (stop_evt) begin
      core_next.st = ST_IDLE;
      core_next.oe_n = 1'h1;
      core_next.hs = 1'h0;
    end

    // thermal: live warning, hysteretic shutdown, sticky shutdown flag
    core_next.warn = flt[ITS_IN_WARN];
    if (flt[ITS_IN_OVER]) begin
      core_next.tsd_act = 1'h1;
    end else if (flt[ITS_IN_COOL]) begin
      core_next.tsd_act = 1'h0;
    end
    // set wins over a host clear in the same cycle
    if (flt[ITS_IN_OVER]) begin
      core_next.tsd_lat = 1'h1;
    end
    core_next.pwr = ~flt[ITS_IN_ANALOG_UV] & ~core_next.tsd_act;

    // lockout of either supply wipes everything but the SCL and SDA samples back to defaults
    if (uv_any) begin
      core_next = CORE_INIT;
      core_next.scl_q = scl_s;
      core_next.sda_q = sda_s;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_reg <= CORE_INIT;
    end else begin
      core_reg <= core_next;
    end
  end

  // open drain: only ever pulls low, never drives high
  assign sda_out = core_reg.drv;
  assign sda_oe_n = core_reg.oe_n;
  assign power_stage_en = core_reg.pwr;
  assign thermal_early_warning_flag = core_reg.warn;
  assign thermal_shutdown_latched_flag = core_reg.tsd_lat;
  assign hs_mode = core_reg.hs;
  assign cfg_out = core_reg.cfg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_ack_match: assert property (
    addr_hit |=> !sda_oe_n ##0 (core_reg.st == ST_AACK))
    else $error("matching address not acknowledged");

  chk_no_ack_other: assert property (
    addr_done && !addr_hit |=> sda_oe_n && core_reg.st == ST_WAIT)
    else $error("foreign address acknowledged");

  chk_hs_code: assert property (
    hs_hit |=> hs_mode && sda_oe_n)
    else $error("high-speed code mishandled");

  chk_stop_release: assert property (
    stop_evt |=> sda_oe_n && !hs_mode && core_reg.st == ST_IDLE)
    else $error("stop did not release the bus");

  chk_start_addr: assert property (
    start_evt && !uv_any |=> core_reg.st == ST_ADDR && core_reg.cnt == 4'h0)
    else $error("start not detected");

  chk_write_commit: assert property (
    commit && core_reg.ptr == 3'h0 |=> cfg_out[7:0] == $past(core_reg.sh))
    else $error("write not committed at acknowledge end");

  chk_hole_zero: assert property (
    load && core_reg.ptr > ITS_STATUS_IDX |=> core_reg.tx == 8'h00 && sda_oe_n == 1'h0)
    else $error("unimplemented index not read as zero");

  chk_tsd_power: assert property (
    flt[ITS_IN_OVER] && !uv_any |=> !power_stage_en && thermal_shutdown_latched_flag)
    else $error("shutdown did not stop power stage");

  chk_tsd_restart: assert property (
    core_reg.tsd_act && !flt[ITS_IN_OVER] && flt[ITS_IN_COOL] && !uv_any
      |=> power_stage_en)
    else $error("no restart after cooling");

  chk_uv_defaults: assert property (
    uv_any |=> cfg_out == CFG_DEFAULT && !thermal_shutdown_latched_flag && sda_oe_n)
    else $error("lockout did not restore defaults");

  chk_warn_flag: assert property (
    $rose(flt[ITS_IN_WARN]) && !uv_any |=> thermal_early_warning_flag)
    else $error("early warning flag not raised");

endmodule
`default_nettype wire

//--- logic/its_pkg.sv
// constants and types shared by the two-wire target and its input filter
package its_pkg;

  // bus identity and protocol figures
  localparam logic [6:0] ITS_DEV_ADDR = 7'h60;
  localparam logic [4:0] ITS_HS_CODE = 5'h01;
  localparam logic ITS_WRITE_DIR = 1'h1;
  localparam logic [3:0] ITS_BITS_PER_BYTE = 4'h8;

  // register map: five plain registers, one status, the rest unimplemented
  localparam int unsigned ITS_CFG_NUM = 5;
  localparam logic [2:0] ITS_STATUS_IDX = 3'h5;
  localparam int unsigned ITS_WARN_BIT = 0;
  localparam int unsigned ITS_TSD_BIT = 1;
  localparam logic [39:0] ITS_CFG_DEFAULT = 40'h00_00_00_00_00;

  // glitch filter: pulses shorter than this are dropped
  localparam int unsigned ITS_CLK_PERIOD_NS = 10;
  localparam int unsigned ITS_FILTER_NS = 30;
  localparam int unsigned ITS_FILTER_CYC = (ITS_FILTER_NS / ITS_CLK_PERIOD_NS < 1) ? 1 :
    ITS_FILTER_NS / ITS_CLK_PERIOD_NS;

  // filtered inputs: index and idle value
  localparam int unsigned ITS_IN_NUM = 7;
  localparam int unsigned ITS_IN_SCL = 0;
  localparam int unsigned ITS_IN_SDA = 1;
  localparam int unsigned ITS_IN_ANALOG_UV = 2;
  localparam int unsigned ITS_IN_VDD_UV = 3;
  localparam int unsigned ITS_IN_WARN = 4;
  localparam int unsigned ITS_IN_OVER = 5;
  localparam int unsigned ITS_IN_COOL = 6;
  localparam logic [6:0] ITS_IN_INIT = 7'h03;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_RX,
    ST_RACK,
    ST_TX,
    ST_TACK,
    ST_WAIT
  } its_state_t;

endpackage

//--- logic/its_pin_filter.sv
// two-flop synchroniser followed by a stability filter for one input
`timescale 1ns/100ps
`default_nettype none
module its_pin_filter
  import its_pkg::*;
#(
  parameter int unsigned LEN = 3,
  parameter logic INIT = 1'h1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic raw_in,
  output logic clean_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] cnt;
    logic clean;
  } its_filt_t;

  localparam its_filt_t FILT_INIT = '{s1: INIT, s2: INIT, cnt: 4'h0, clean: INIT};
  localparam logic [3:0] LAST = 4'(LEN - 1);

  its_filt_t filt_reg;
  its_filt_t filt_next;

  // output follows only after LEN equal samples, so short spikes vanish
  always_comb begin
    filt_next = filt_reg;
    filt_next.s1 = raw_in;
    filt_next.s2 = filt_reg.s1;
    if (filt_reg.s2 == filt_reg.clean) begin
      filt_next.cnt = 4'h0;
    end else if (filt_reg.cnt >= LAST) begin
      filt_next.clean = filt_reg.s2;
      filt_next.cnt = 4'h0;
    end else begin
      filt_next.cnt = filt_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      filt_reg <= FILT_INIT;
    end else begin
      filt_reg <= filt_next;
    end
  end

  assign clean_out = filt_reg.clean;

endmodule
`default_nettype wire

//--- verification/its_host_model.sv
// bus controller model: bit-banged start, stop, byte transfer over an open-drain data line
`timescale 1ns/100ps
`default_nettype none
module its_host_model (
  input wire logic ref_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // lines idle released, pulled high
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // low phase kept at 100 ns, the shortest the target is promised to follow
  task automatic put_bit(input logic b, output logic got);
    scl <= 1'h0;
    gap(5);
    sda_drv <= b;
    gap(5);
    scl <= 1'h1;
    gap(6);
    got = sda_wire;
  endtask

  // also serves as repeated start when entered with the clock high
  task automatic start_cond();
    scl <= 1'h0;
    gap(5);
    sda_drv <= 1'h1;
    gap(5);
    scl <= 1'h1;
    gap(6);
    sda_drv <= 1'h0;
    gap(6);
  endtask

  task automatic stop_cond();
    scl <= 1'h0;
    gap(5);
    sda_drv <= 1'h0;
    gap(5);
    scl <= 1'h1;
    gap(6);
    sda_drv <= 1'h1;
    gap(6);
  endtask

  // msb first, then the ninth bit is released for the receiver
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], g);
    end
    put_bit(1'h1, g);
    ack = ~g;
  endtask

  task automatic recv_byte(input logic host_ack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'h1, d[i]);
    end
    put_bit(~host_ack, g);
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the two-wire target with thermal and lockout status
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb;
  import its_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic scl, sda_drv, sda_out, sda_oe_n;
  logic analog_uv = 1'h0;
  logic vdd_uv = 1'h0;
  logic warn = 1'h0;
  logic over = 1'h0;
  logic cooled = 1'h1;
  logic power_stage_en, warn_flag, tsd_flag, hs_mode;
  logic [39:0] cfg_out;
  wire sda_wire = sda_drv & (sda_oe_n | sda_out);
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // rows: index, value written, value read back
  logic [18:0] rows [5] = '{{3'h0, 8'ha5, 8'ha5}, {3'h4, 8'h3c, 8'h3c}, {3'h6, 8'hff, 8'h00},
    {3'h7, 8'h11, 8'h00}, {3'h2, 8'h80, 8'h80}};
  // other address, general call, ten-bit prefix, high-speed code
  logic [7:0] bad [4] = '{8'hc3, 8'h00, 8'hf1, 8'h09};

  always #5 ref_clk = ~ref_clk;

  its_host_model host_u (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

  its_target dut_u (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .analog_undervoltage_lockout(analog_uv),
    .vdd_undervoltage_lockout(vdd_uv), .temp_above_warn(warn), .temp_above_shutdown(over),
    .temp_cooled(cooled), .power_stage_en(power_stage_en),
    .thermal_early_warning_flag(warn_flag), .thermal_shutdown_latched_flag(tsd_flag),
    .hs_mode(hs_mode), .cfg_out(cfg_out));

  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 11300 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic addr_frame(input logic [7:0] a, input logic exp_ack);
    logic k;
    host_u.start_cond();
    host_u.send_byte(a, k);
    `CHK("addr_ack", exp_ack, k)
  endtask

  task automatic write_reg(input logic [2:0] idx, input logic [7:0] d);
    logic k;
    addr_frame({ITS_DEV_ADDR, ITS_WRITE_DIR}, 1'h1);
    host_u.send_byte({5'h00, idx}, k);
    `CHK("idx_ack", 1'h1, k)
    host_u.send_byte(d, k);
    `CHK("data_ack", 1'h1, k)
    host_u.stop_cond();
  endtask

  // index written first, then repeated start in the read direction
  task automatic read_check(input logic [2:0] idx, input logic [7:0] exp);
    logic k;
    logic [7:0] d;
    addr_frame({ITS_DEV_ADDR, ITS_WRITE_DIR}, 1'h1);
    host_u.send_byte({5'h00, idx}, k);
    addr_frame({ITS_DEV_ADDR, ~ITS_WRITE_DIR}, 1'h1);
    host_u.recv_byte(1'h0, d);
    host_u.stop_cond();
    `CHK("read_data", exp, d)
  endtask

  initial begin
    logic k;
    logic [7:0] d;
    cyc(4);
    `CHK("cfg_in_reset", 40'h0, cfg_out)
    `CHK("released_in_reset", 1'h1, sda_oe_n)
    `CHK("sda_drive_low", 1'h0, sda_out)
    cyc(1);
    reset <= 1'h0;
    cyc(15);
    `CHK("power_after_reset", 1'h1, power_stage_en)
    for (int i = 0; i < 5; i++) begin
      write_reg(rows[i][18:16], rows[i][15:8]);
      if (rows[i][18:16] < 3'h5) begin
        `CHK("cfg_byte", rows[i][15:8], cfg_out[rows[i][18:16] * 8 +: 8])
      end
      read_check(rows[i][18:16], rows[i][7:0]);
    end
    // controller ack asks for more; with no auto-increment the same byte comes again
    addr_frame({ITS_DEV_ADDR, ITS_WRITE_DIR}, 1'h1);
    host_u.send_byte({5'h00, 3'h0}, k);
    addr_frame({ITS_DEV_ADDR, ~ITS_WRITE_DIR}, 1'h1);
    host_u.recv_byte(1'h1, d);
    `CHK("read_first", 8'ha5, d)
    host_u.recv_byte(1'h0, d);
    `CHK("read_again", 8'ha5, d)
    host_u.stop_cond();
    for (int i = 0; i < 4; i++) begin
      addr_frame(bad[i], 1'h0);
      if (i == 3) begin
        `CHK("hs_mode_on", 1'h1, hs_mode)
      end
      host_u.stop_cond();
    end
    cyc(10);
    `CHK("hs_mode_off", 1'h0, hs_mode)
    // thermal warning, then shutdown with the bus still in use
    warn <= 1'h1;
    cyc(10);
    `CHK("warn_flag", 1'h1, warn_flag)
    over <= 1'h1;
    cooled <= 1'h0;
    cyc(10);
    `CHK("power_off_hot", 1'h0, power_stage_en)
    `CHK("tsd_latched", 1'h1, tsd_flag)
    write_reg(3'h3, 8'h5a);
    `CHK("cfg_during_tsd", 40'h3c_5a_80_00_a5, cfg_out)
    over <= 1'h0;
    cyc(10);
    `CHK("still_off_warm", 1'h0, power_stage_en)
    cooled <= 1'h1;
    cyc(10);
    `CHK("power_on_cooled", 1'h1, power_stage_en)
    read_check(ITS_STATUS_IDX, 8'h03);
    write_reg(ITS_STATUS_IDX, 8'h02);
    read_check(ITS_STATUS_IDX, 8'h01);
    // supply lockouts wipe the registers
    write_reg(3'h1, 8'h77);
    vdd_uv <= 1'h1;
    cyc(20);
    `CHK("cfg_vdd_lockout", 40'h0, cfg_out)
    vdd_uv <= 1'h0;
    cyc(10);
    write_reg(3'h1, 8'h77);
    analog_uv <= 1'h1;
    cyc(10);
    `CHK("power_analog_lockout", 1'h0, power_stage_en)
    `CHK("cfg_analog_lockout", 40'h0, cfg_out)
    addr_frame({ITS_DEV_ADDR, ITS_WRITE_DIR}, 1'h0);
    host_u.stop_cond();
    analog_uv <= 1'h0;
    cyc(15);
    read_check(3'h1, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
